/* File: seq_pkg.sv */
// Constants and types shared by the converter sequencer end and the host end.
// Assumes a single 40 MHz clock for both ends and one link between them.
//
// How it works
// - Hardware sequencer runs only while enable pin high.
// - Hardware sequencer last step comes from channel-select pins; burst comes from the software setting.
// - Software mode programs every sequencer option.
// - Sequence list holds 32 programmable channel-pair steps.
// - Any channel, diagnostic too, at any step.
// - Software steps pair any A with B or diagnostic.
// - Burst: one start pulse converts whole sequence.
// - No burst: one pulse per step, then advance.
// - Burst ignored while the sequencer is disabled.
// - Hardware mode converts matched A/B channel indices only.
// - Results leave in programmed sequence order.
// - Start converts on rising edge while busy low.
// - Busy stays high through the whole burst.
package seq_pkg;

  // ****************************************************************
  // Sizes and codes
  // ****************************************************************
  localparam int SEQ_STEPS = 32;
  localparam int STEP_W = 5;
  localparam int CHAN_W = 4;
  localparam int SAMPLE_W = 16;
  localparam int SEL_W = 3;
  localparam logic [CHAN_W-1:0] DIAG_CHAN = 4'h8;
  localparam logic [STEP_W-1:0] STEP_RESET = 5'h00;
  localparam int PAIR_W = 2 * CHAN_W;
  localparam int RES_W = STEP_W + PAIR_W + 2 * SAMPLE_W;
  localparam int FIFO_DEPTH = 8;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_TIME_NS = 500;
  localparam int START_HIGH_NS = 50;
  // Least times round up to whole cycles.
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_CYCLES = (START_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_PUSH = 2'b10
  } seq_state_type;

endpackage

/* File: seq_link_if.sv */
// Link between the converter sequencer end and the host controller end.
// Assumes both ends share ref_clk_in; the testbench joins them here.
`timescale 1ns/1ps
interface seq_link_if;
  import seq_pkg::*;

  // Conversion control and mode pins.
  logic convert_start_pulse;
  logic busy;
  logic hw_mode;
  logic sequencer_enable_pin;
  logic [SEL_W-1:0] channel_select_pins;
  // Software programming port.
  logic prog_we;
  logic [STEP_W-1:0] prog_addr;
  logic [PAIR_W-1:0] prog_data;
  logic cfg_we;
  logic [STEP_W-1:0] cfg_last;
  logic cfg_burst;
  logic cfg_seq_en;
  // Result stream.
  logic res_valid;
  logic res_ready;
  logic [RES_W-1:0] res_data;

  modport device (
    input convert_start_pulse, hw_mode, sequencer_enable_pin, channel_select_pins,
    input prog_we, prog_addr, prog_data, cfg_we, cfg_last, cfg_burst, cfg_seq_en,
    input res_ready,
    output busy, res_valid, res_data
  );

  modport host (
    output convert_start_pulse, hw_mode, sequencer_enable_pin, channel_select_pins,
    output prog_we, prog_addr, prog_data, cfg_we, cfg_last, cfg_burst, cfg_seq_en,
    output res_ready,
    input busy, res_valid, res_data
  );

endinterface

/* File: seq_fifo.sv */
// Result FIFO with valid/ready on both sides.
// Assumes one clock; the reader may stall so the FIFO can fill.
`timescale 1ns/1ps
module seq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Fill side.
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side.
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [PTR_W:0] count;
  } fifo_state_type;

  fifo_state_type s_reg;
  fifo_state_type s_next;
  logic push;
  logic pop;

  // Full and empty follow the occupancy count.
  assign in_ready_out = (s_reg.count != (PTR_W + 1)'(DEPTH));
  assign out_valid_out = (s_reg.count != '0);
  assign out_data_out = s_reg.mem[s_reg.rptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Pointer and storage update.
  always_comb
  begin
    s_next = s_reg;
    if (push)
    begin
      s_next.mem[s_reg.wptr] = in_data_in;
      s_next.wptr = (s_reg.wptr == PTR_W'(DEPTH - 1)) ? '0 : s_reg.wptr + 1'b1;
    end
    if (pop)
    begin
      s_next.rptr = (s_reg.rptr == PTR_W'(DEPTH - 1)) ? '0 : s_reg.rptr + 1'b1;
    end
    if (push && !pop)
    begin
      s_next.count = s_reg.count + 1'b1;
    end
    else if (pop && !push)
    begin
      s_next.count = s_reg.count - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule

/* File: seq_device.sv */
// Converter channel sequencer end: sequence list, burst control and result stream.
// Assumes the host end drives the link and the analog samples are ready
// on the sample inputs when the conversion time has run out.
`timescale 1ns/1ps
module seq_device (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Link to the host.
  seq_link_if.device link,
  // Input multiplexer and sampled data.
  output logic [seq_pkg::CHAN_W-1:0] mux_a_sel_out,
  output logic [seq_pkg::CHAN_W-1:0] mux_b_sel_out,
  output logic sampling_out,
  input wire logic [seq_pkg::SAMPLE_W-1:0] sample_a_in,
  input wire logic [seq_pkg::SAMPLE_W-1:0] sample_b_in
);
  import seq_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    seq_state_type state;
    logic start_prev;
    logic [SEQ_STEPS-1:0][PAIR_W-1:0] list;
    logic [STEP_W-1:0] last_step;
    logic burst;
    logic sw_seq_en;
    logic [STEP_W-1:0] step;
    logic [STEP_W-1:0] run_last;
    logic run_seq;
    logic run_burst;
    logic run_hw;
    logic [CHAN_W-1:0] a_ch;
    logic [CHAN_W-1:0] b_ch;
    logic [CNT_W-1:0] count;
    logic [RES_W-1:0] result;
  } dev_state_type;

  dev_state_type s_reg;
  dev_state_type s_next;
  logic start_edge;
  logic seq_active;
  logic fifo_ready;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Zero-extends a matched hardware channel index to a channel code.
  function automatic logic [CHAN_W-1:0] hw_chan(input logic [STEP_W-1:0] idx);
    hw_chan = CHAN_W'(idx[SEL_W-1:0]);
  endfunction

  // Picks the group A channel out of a stored list entry.
  function automatic logic [CHAN_W-1:0] pair_a(input logic [PAIR_W-1:0] pair);
    pair_a = pair[PAIR_W-1:CHAN_W];
  endfunction

  // Picks the group B channel, or the diagnostic code, out of a list entry.
  function automatic logic [CHAN_W-1:0] pair_b(input logic [PAIR_W-1:0] pair);
    pair_b = pair[CHAN_W-1:0];
  endfunction

  // Only a fresh rising edge seen while idle starts work.
  assign start_edge = link.convert_start_pulse && !s_reg.start_prev;
  assign seq_active = link.hw_mode ? link.sequencer_enable_pin : s_reg.sw_seq_en;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    s_next = s_reg;
    s_next.start_prev = link.convert_start_pulse;
    case (s_reg.state)
      ST_IDLE:
      begin
        // Programming is taken between conversions in software mode only.
        if (!link.hw_mode && link.prog_we)
        begin
          s_next.list[link.prog_addr] = link.prog_data;
        end
        if (!link.hw_mode && link.cfg_we)
        begin
          s_next.last_step = link.cfg_last;
          s_next.burst = link.cfg_burst;
          s_next.sw_seq_en = link.cfg_seq_en;
          s_next.step = STEP_RESET;
        end
        if (start_edge)
        begin
          s_next.state = ST_CONVERT;
          s_next.count = '0;
          s_next.run_seq = seq_active;
          s_next.run_hw = link.hw_mode;
          s_next.run_burst = seq_active && s_reg.burst;
          // Hardware sequence length comes from the select pins.
          s_next.run_last = link.hw_mode ? STEP_W'(link.channel_select_pins)
                                         : s_reg.last_step;
          // The pair is fixed here and held for the whole conversion.
          if (!seq_active)
          begin
            s_next.step = STEP_RESET;
            s_next.a_ch = CHAN_W'(link.channel_select_pins);
            s_next.b_ch = CHAN_W'(link.channel_select_pins);
          end
          else if (link.hw_mode)
          begin
            s_next.a_ch = hw_chan(s_reg.step);
            s_next.b_ch = hw_chan(s_reg.step);
          end
          else
          begin
            s_next.a_ch = pair_a(s_reg.list[s_reg.step]);
            s_next.b_ch = pair_b(s_reg.list[s_reg.step]);
          end
        end
      end
      ST_CONVERT:
      begin
        // Start edges here are not acted on; only the edge tracker moves.
        s_next.count = s_reg.count + 1'b1;
        if (s_reg.count == CNT_W'(CONV_CYCLES - 1))
        begin
          s_next.result = {s_reg.step, s_reg.a_ch, s_reg.b_ch, sample_a_in, sample_b_in};
          s_next.state = ST_PUSH;
        end
      end
      default:
      begin
        // A full FIFO holds the sequencer here with busy still high.
        if (fifo_ready)
        begin
          if (!s_reg.run_seq || s_reg.step >= s_reg.run_last)
          begin
            s_next.step = STEP_RESET;
          end
          else
          begin
            s_next.step = s_reg.step + 1'b1;
          end
          if (s_reg.run_burst && s_reg.step < s_reg.run_last)
          begin
            // Next pair of the burst starts without a new start pulse.
            s_next.state = ST_CONVERT;
            s_next.count = '0;
            if (s_reg.run_hw)
            begin
              s_next.a_ch = hw_chan(s_reg.step + 1'b1);
              s_next.b_ch = hw_chan(s_reg.step + 1'b1);
            end
            else
            begin
              s_next.a_ch = pair_a(s_reg.list[s_reg.step + 1'b1]);
              s_next.b_ch = pair_b(s_reg.list[s_reg.step + 1'b1]);
            end
          end
          else
          begin
            s_next.state = ST_IDLE;
          end
        end
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset also clears the list, so the host must program it again.
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Result FIFO and outputs
  // ****************************************************************
  // Results enter in conversion order, which is sequence order.
  seq_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .in_valid_in(s_reg.state == ST_PUSH),
    .in_ready_out(fifo_ready),
    .in_data_in(s_reg.result),
    .out_valid_out(link.res_valid),
    .out_ready_in(link.res_ready),
    .out_data_out(link.res_data)
  );

  // Busy covers every non-idle state, so a burst holds it throughout.
  assign link.busy = (s_reg.state != ST_IDLE);
  assign mux_a_sel_out = s_reg.a_ch;
  assign mux_b_sel_out = s_reg.b_ch;
  assign sampling_out = (s_reg.state == ST_CONVERT);

endmodule

/* File: seq_host.sv */
// Host controller end: issues start pulses, drives mode pins, programs the
// sequence list and collects results. Assumes seq_device on the far side.
`timescale 1ns/1ps
module seq_host (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Link to the converter.
  seq_link_if.host link,
  // Conversion request.
  input wire logic start_req_in,
  output logic start_ready_out,
  // Mode pins.
  input wire logic hw_mode_in,
  input wire logic seq_enable_in,
  input wire logic [seq_pkg::SEL_W-1:0] chan_select_in,
  // Programming requests.
  input wire logic prog_we_in,
  input wire logic [seq_pkg::STEP_W-1:0] prog_addr_in,
  input wire logic [seq_pkg::PAIR_W-1:0] prog_data_in,
  input wire logic cfg_we_in,
  input wire logic [seq_pkg::STEP_W-1:0] cfg_last_in,
  input wire logic cfg_burst_in,
  input wire logic cfg_seq_en_in,
  // Results.
  output logic result_valid_out,
  input wire logic result_ready_in,
  output logic [seq_pkg::RES_W-1:0] result_data_out
);
  import seq_pkg::*;

  typedef struct packed {
    logic start;
    logic [CNT_W-1:0] count;
    logic hw_mode;
    logic seq_en;
    logic [SEL_W-1:0] sel;
    logic prog_we;
    logic [STEP_W-1:0] prog_addr;
    logic [PAIR_W-1:0] prog_data;
    logic cfg_we;
    logic [STEP_W-1:0] cfg_last;
    logic cfg_burst;
    logic cfg_seq_en;
    logic res_valid;
    logic [RES_W-1:0] res_data;
  } host_state_type;

  host_state_type s_reg;
  host_state_type s_next;

  // A start may go out only while the converter is idle.
  assign start_ready_out = !link.busy && !s_reg.start;
  assign link.res_ready = !s_reg.res_valid || result_ready_in;

  // ****************************************************************
  // Pin and request staging
  // ****************************************************************
  always_comb
  begin
    s_next = s_reg;
    s_next.hw_mode = hw_mode_in;
    s_next.seq_en = seq_enable_in;
    s_next.sel = chan_select_in;
    s_next.prog_we = prog_we_in && !link.busy;
    s_next.prog_addr = prog_addr_in;
    s_next.prog_data = prog_data_in;
    s_next.cfg_we = cfg_we_in && !link.busy;
    s_next.cfg_last = cfg_last_in;
    s_next.cfg_burst = cfg_burst_in;
    s_next.cfg_seq_en = cfg_seq_en_in;
    // Start pulse is held high long enough for busy to be seen.
    if (s_reg.start)
    begin
      s_next.count = s_reg.count + 1'b1;
      if (s_reg.count == CNT_W'(START_CYCLES - 1))
      begin
        s_next.start = 1'b0;
      end
    end
    else if (start_req_in && !link.busy)
    begin
      s_next.start = 1'b1;
      s_next.count = '0;
    end
    // Results are taken in arrival order.
    if (link.res_valid && link.res_ready)
    begin
      s_next.res_valid = 1'b1;
      s_next.res_data = link.res_data;
    end
    else if (result_ready_in)
    begin
      s_next.res_valid = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Link and user outputs from flip-flops.
  assign link.convert_start_pulse = s_reg.start;
  assign link.hw_mode = s_reg.hw_mode;
  assign link.sequencer_enable_pin = s_reg.seq_en;
  assign link.channel_select_pins = s_reg.sel;
  assign link.prog_we = s_reg.prog_we;
  assign link.prog_addr = s_reg.prog_addr;
  assign link.prog_data = s_reg.prog_data;
  assign link.cfg_we = s_reg.cfg_we;
  assign link.cfg_last = s_reg.cfg_last;
  assign link.cfg_burst = s_reg.cfg_burst;
  assign link.cfg_seq_en = s_reg.cfg_seq_en;
  assign result_valid_out = s_reg.res_valid;
  assign result_data_out = s_reg.res_data;

endmodule

/* File: seq_link_properties.sv */
// Concurrent checks on the link between the converter end and the host end.
// Assumes one clock and an active-low asynchronous reset shared by both ends.
`timescale 1ns/1ps
module seq_link_properties
  import seq_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Link signals.
  input wire logic convert_start_pulse,
  input wire logic busy,
  input wire logic prog_we,
  input wire logic cfg_we,
  input wire logic res_valid,
  input wire logic res_ready,
  input wire logic [RES_W-1:0] res_data
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  localparam int MIN_BUSY = 21;
  logic [CNT_W-1:0] busy_cnt_reg;
  logic [CNT_W-1:0] busy_cnt_next;

  // Counts the cycles of the current busy stretch and saturates.
  always_comb
  begin
    busy_cnt_next = busy ? busy_cnt_reg + 8'h01 : 8'h00;
    if (busy && busy_cnt_reg == 8'hFF)
    begin
      busy_cnt_next = busy_cnt_reg;
    end
  end

  // Registers the busy count.
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      busy_cnt_reg <= 8'h00;
    end
    else
    begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  // ****************************************************************
  // Sequences and assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // A start edge seen while the converter is idle.
  sequence start_taken_s;
    !busy && $rose(convert_start_pulse);
  endsequence

  // The start pin stays high two cycles, then drops.
  sequence start_pulse_s;
    convert_start_pulse [*2] ##1 !convert_start_pulse;
  endsequence

  // No result 20 cycles after busy rises, then one appears a cycle later.
  sequence conv_result_s;
    ##20 !res_valid ##1 res_valid;
  endsequence

  a_start_taken: assert property (start_taken_s |=> busy)
    else $error("busy did not follow an accepted start");
  a_busy_cause: assert property ($rose(busy) |->
    $past(convert_start_pulse) && !$past(convert_start_pulse, 2))
    else $error("busy rose without a start edge");
  a_host_start_legal: assert property (busy |-> !$rose(convert_start_pulse))
    else $error("start raised while busy");
  a_start_width: assert property ($rose(convert_start_pulse) |-> start_pulse_s)
    else $error("start pulse width wrong");
  a_busy_min_len: assert property ($fell(busy) |-> busy_cnt_reg >= MIN_BUSY)
    else $error("busy dropped before the conversion ended");
  a_result_latency: assert property (($rose(busy) && !res_valid) |-> conv_result_s)
    else $error("result timing wrong");
  a_result_hold: assert property (res_valid && !res_ready |=>
    res_valid && $stable(res_data))
    else $error("stalled result changed");
  a_prog_idle: assert property ((prog_we || cfg_we) |-> !$past(busy))
    else $error("programming forwarded while busy");
endmodule

/* File: test_adc_channel_sequencer_burst.sv */
// Self-checking bench joining the converter end and the host end.
// Assumes the package, interface, design modules and checker are compiled first.
`timescale 1ns/1ps
module test_adc_channel_sequencer_burst;
  import seq_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  typedef struct packed {logic [SEL_W-1:0] sel; logic [STEP_W-1:0] step;
    logic [PAIR_W-1:0] pair;} row_type;
  row_type rows[5] = '{'{3'h1, 5'h00, 8'h02}, '{3'h6, 5'h01, 8'h17},
    '{3'h2, 5'h02, 8'h23}, '{3'h7, 5'h03, 8'h38}, '{3'h0, 5'h00, 8'h02}};
  logic ref_clk_in, rst_b_in, start_req_in, start_ready_out, hw_mode_in, seq_enable_in;
  logic prog_we_in, cfg_we_in, cfg_burst_in, cfg_seq_en_in, result_valid_out, result_ready_in;
  logic [SEL_W-1:0] chan_select_in;
  logic [STEP_W-1:0] prog_addr_in, cfg_last_in;
  logic [PAIR_W-1:0] prog_data_in;
  logic [RES_W-1:0] result_data_out;
  logic [CHAN_W-1:0] mux_a_sel_out, mux_b_sel_out;
  logic sampling_out;
  logic [SAMPLE_W-1:0] sample_a_in, sample_b_in;
  logic [RES_W-1:0] got_q[$];
  int failures = 0;
  int compares = 0;

  // ****************************************************************
  // Design, link and checker
  // ****************************************************************
  seq_link_if u_seq_link_if ();
  seq_device u_seq_device (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .link(u_seq_link_if),
    .mux_a_sel_out(mux_a_sel_out), .mux_b_sel_out(mux_b_sel_out), .sampling_out(sampling_out),
    .sample_a_in(sample_a_in), .sample_b_in(sample_b_in));
  seq_host u_seq_host (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .link(u_seq_link_if),
    .start_req_in(start_req_in), .start_ready_out(start_ready_out), .hw_mode_in(hw_mode_in),
    .seq_enable_in(seq_enable_in), .chan_select_in(chan_select_in), .prog_we_in(prog_we_in),
    .prog_addr_in(prog_addr_in), .prog_data_in(prog_data_in), .cfg_we_in(cfg_we_in),
    .cfg_last_in(cfg_last_in), .cfg_burst_in(cfg_burst_in), .cfg_seq_en_in(cfg_seq_en_in),
    .result_valid_out(result_valid_out), .result_ready_in(result_ready_in),
    .result_data_out(result_data_out));
  seq_link_properties u_seq_link_properties (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .convert_start_pulse(u_seq_link_if.convert_start_pulse), .busy(u_seq_link_if.busy),
    .prog_we(u_seq_link_if.prog_we), .cfg_we(u_seq_link_if.cfg_we),
    .res_valid(u_seq_link_if.res_valid), .res_ready(u_seq_link_if.res_ready),
    .res_data(u_seq_link_if.res_data));

  // Front-end stand-in: each sample carries the channel routed to it.
  assign sample_a_in = {12'hA5C, mux_a_sel_out};
  assign sample_b_in = {12'h3B0, mux_b_sel_out};

  // Clock at 40 MHz.
  initial
  begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  // Collects every result word that the host hands over, mid-cycle while settled.
  always @(negedge ref_clk_in)
  begin
    if (result_valid_out === 1'b1 && result_ready_in === 1'b1)
    begin
      got_q.push_back(result_data_out);
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [RES_W-1:0] exp,
    input logic [RES_W-1:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Moves to just after the next rising edge.
  task automatic tick();
    @(posedge ref_clk_in);
    #2;
  endtask

  // Waits, bounded, until the host can take a request.
  task automatic wait_ready();
    int n;
    n = 0;
    while (start_ready_out !== 1'b1 && n < 3000)
    begin
      tick();
      n++;
    end
    if (n == 3000)
    begin
      failures++;
    end
  endtask

  task automatic prog(input int i, input logic [PAIR_W-1:0] p);
    wait_ready();
    prog_we_in = 1'b1;
    prog_addr_in = 5'(i);
    prog_data_in = p;
    tick();
    prog_we_in = 1'b0;
    tick();
  endtask

  task automatic cfg(input logic [STEP_W-1:0] last, input logic burst, input logic en);
    wait_ready();
    cfg_we_in = 1'b1;
    cfg_last_in = last;
    cfg_burst_in = burst;
    cfg_seq_en_in = en;
    tick();
    cfg_we_in = 1'b0;
    tick();
  endtask

  task automatic start_one();
    wait_ready();
    start_req_in = 1'b1;
    tick();
    start_req_in = 1'b0;
    tick();
  endtask

  // Takes the next result; a set any_step masks the step field.
  task automatic expect_res(input logic [STEP_W-1:0] st, input logic any_step,
    input logic [PAIR_W-1:0] p);
    logic [RES_W-1:0] w;
    int n;
    n = 0;
    while (got_q.size() == 0 && n < 3000)
    begin
      tick();
      n++;
    end
    w = (got_q.size() > 0) ? got_q.pop_front() : 'x;
    if (any_step)
    begin
      w[RES_W-1 -: STEP_W] = st;
    end
    chk_word("result", {st, p, 12'hA5C, p[7:4], 12'h3B0, p[3:0]}, w);
  endtask

  // Expected pair of a list step; channel 8 is the diagnostic channel.
  function automatic logic [PAIR_W-1:0] list_pair(input int i);
    list_pair = {4'(i % 9), 4'((i * 5 + 2) % 9)};
  endfunction

  // ****************************************************************
  // Watchdog and main sequence
  // ****************************************************************
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    failures++;
    report_and_stop();
  end

  initial
  begin
    {rst_b_in, start_req_in, hw_mode_in, seq_enable_in, prog_we_in, cfg_we_in} = 6'h00;
    {cfg_burst_in, cfg_seq_en_in, chan_select_in, prog_addr_in, cfg_last_in} = 15'h0000;
    prog_data_in = 8'h00;
    result_ready_in = 1'b1;
    repeat (16) @(posedge ref_clk_in);
    #2;
    rst_b_in = 1'b1;
    tick();
    chk_bit("busy after reset", 1'b0, u_seq_link_if.busy);
    chk_bit("ready after reset", 1'b1, start_ready_out);
    for (int i = 0; i < SEQ_STEPS; i++) prog(i, list_pair(i));
    cfg(5'h03, 1'b0, 1'b1);
    for (int r = 0; r < 5; r++)
    begin
      chan_select_in = rows[r].sel;
      start_one();
      expect_res(rows[r].step, 1'b0, rows[r].pair);
    end
    // Full 32-step burst against a stalled reader fills the FIFO.
    cfg(5'h1F, 1'b1, 1'b1);
    result_ready_in = 1'b0;
    start_one();
    repeat (400) tick();
    chk_bit("busy while stalled", 1'b1, u_seq_link_if.busy);
    chk_bit("ready while busy", 1'b0, start_ready_out);
    chk_bit("nothing delivered", 1'b1, got_q.size() == 0);
    result_ready_in = 1'b1;
    for (int i = 0; i < SEQ_STEPS; i++)
    begin
      expect_res(5'(i), 1'b0, list_pair(i));
      if (i == 15) chk_bit("busy mid burst", 1'b1, u_seq_link_if.busy);
    end
    // Burst with the sequencer off gives one pin-selected pair.
    cfg(5'h02, 1'b1, 1'b0);
    chan_select_in = 3'h5;
    tick();
    start_one();
    expect_res(5'h00, 1'b1, 8'h55);
    repeat (80) tick();
    chk_bit("single result", 1'b1, got_q.size() == 0);
    // Pin-driven sequence of matched pairs; programming is refused here.
    hw_mode_in = 1'b1;
    seq_enable_in = 1'b1;
    chan_select_in = 3'h2;
    tick();
    prog(0, 8'h77);
    start_one();
    for (int i = 0; i < 3; i++) expect_res(5'(i), 1'b0, {4'(i), 4'(i)});
    seq_enable_in = 1'b0;
    tick();
    start_one();
    expect_res(5'h00, 1'b1, 8'h22);
    hw_mode_in = 1'b0;
    tick();
    cfg(5'h00, 1'b0, 1'b1);
    start_one();
    expect_res(5'h00, 1'b0, 8'h02);
    // Reset in mid-conversion clears busy and the result path.
    start_one();
    repeat (5) tick();
    chk_bit("sampling", 1'b1, sampling_out);
    rst_b_in = 1'b0;
    tick();
    chk_bit("busy in reset", 1'b0, u_seq_link_if.busy);
    chk_bit("valid in reset", 1'b0, result_valid_out);
    rst_b_in = 1'b1;
    tick();
    chk_bit("ready after second reset", 1'b1, start_ready_out);
    report_and_stop();
  end
endmodule
